/* inc/ccsr_regs.svh */
`ifndef CCSR_REGS_SVH
`define CCSR_REGS_SVH

// =====================================================================
// Special-register addresses.
`define CCSR_ADDR_P0_LOW    8'h82
`define CCSR_ADDR_P0_HIGH   8'h83
`define CCSR_ADDR_P1_LOW    8'h84
`define CCSR_ADDR_P1_HIGH   8'h85
`define CCSR_ADDR_PWR       8'h87
`define CCSR_ADDR_PSW_MAIN  8'hD0
`define CCSR_ADDR_PSW_HOLD  8'hD8
`define CCSR_ADDR_ACC       8'hE0
`define CCSR_ADDR_MULDIV    8'hF0

// =====================================================================
// Reset value shared by every register.
`define CCSR_RESET_BYTE     8'h00

// =====================================================================
// Power control field positions.
`define CCSR_PWR_DOUBLE     7
`define CCSR_PWR_UART_EN    6
`define CCSR_PWR_SEL        3
`define CCSR_PWR_DOWN       1
`define CCSR_PWR_SLEEP      0

// =====================================================================
// Status word field positions.
`define CCSR_PSW_CARRY      7
`define CCSR_PSW_AUX        6
`define CCSR_PSW_USER0      5
`define CCSR_PSW_BANK_HI    4
`define CCSR_PSW_BANK_LO    3
`define CCSR_PSW_RANGE      2
`define CCSR_PSW_USER1      1
`define CCSR_PSW_PARITY     0
`define CCSR_HOLD_FLAG      0

// =====================================================================
// Arithmetic limits.
`define CCSR_BYTE_MAX       16'h00FF
`define CCSR_NIBBLE_BIT     4

`endif

/* inc/ccsr_pkg.sv */
package ccsr_pkg;

  // ===================================================================
  // Arithmetic operation reported by the execution unit.
  typedef enum logic [2:0] {
    CCSR_OP_NONE = 3'b000,
    CCSR_OP_ADD  = 3'b001,
    CCSR_OP_ADDC = 3'b010,
    CCSR_OP_SUBB = 3'b011,
    CCSR_OP_MUL  = 3'b100,
    CCSR_OP_DIV  = 3'b101
  } ccsr_op_e;

  // Special-register access from the execution unit.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccsr_sfr_s;

  // Arithmetic request: operation, operands and carry in.
  typedef struct packed {
    ccsr_op_e   op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
  } ccsr_alu_s;

  // Arithmetic result: main byte, second byte and flags.
  typedef struct packed {
    logic [7:0] res;
    logic [7:0] res_b;
    logic       carry;
    logic       aux;
    logic       range;
  } ccsr_flags_s;

endpackage : ccsr_pkg

/* hw/ccsr_arith.sv */
`timescale 1ns/10ps
`include "ccsr_regs.svh"

// Combinational arithmetic unit that computes results and flags.
module ccsr_arith
  import ccsr_pkg::*;
(
  // Request.
  input  ccsr_alu_s   req,
  // Result.
  output ccsr_flags_s rsp
);

  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [15:0] prod;

  // =====================================================================
  // Flag computation for add, subtract, multiply and divide.
  always_comb begin
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'h0000;
    rsp  = '0;
    unique case (req.op)
      CCSR_OP_ADD, CCSR_OP_ADDC: begin
        sum9 = {1'b0, req.a} + {1'b0, req.b} + {8'h00, req.op == CCSR_OP_ADDC && req.cin};
        nib5 = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, req.op == CCSR_OP_ADDC && req.cin};
        rsp.res   = sum9[7:0];
        rsp.carry = sum9[8];
        rsp.aux   = nib5[`CCSR_NIBBLE_BIT];
        rsp.range = (req.a[7] == req.b[7]) && (sum9[7] != req.a[7]);
      end
      CCSR_OP_SUBB: begin
        sum9 = {1'b0, req.a} - {1'b0, req.b} - {8'h00, req.cin};
        nib5 = {1'b0, req.a[3:0]} - {1'b0, req.b[3:0]} - {4'h0, req.cin};
        rsp.res   = sum9[7:0];
        rsp.carry = sum9[8];
        rsp.aux   = nib5[`CCSR_NIBBLE_BIT];
        rsp.range = (req.a[7] != req.b[7]) && (sum9[7] != req.a[7]);
      end
      CCSR_OP_MUL: begin
        prod = req.a * req.b;
        rsp.res   = prod[7:0];
        rsp.res_b = prod[15:8];
        rsp.range = prod > `CCSR_BYTE_MAX;
      end
      CCSR_OP_DIV: begin
        if (req.b == 8'h00) begin
          rsp.range = 1'b1;
        end else begin
          rsp.res   = req.a / req.b;
          rsp.res_b = req.a % req.b;
        end
      end
      default: begin
        rsp = '0;
      end
    endcase
  end

endmodule : ccsr_arith

/* hw/ccsr_ptr.sv */
`timescale 1ns/10ps
`include "ccsr_regs.svh"

// One 16-bit data pointer, written byte by byte.
module ccsr_ptr
  import ccsr_pkg::*;
#(
  parameter logic [7:0] LOW_ADDR  = `CCSR_ADDR_P0_LOW,
  parameter logic [7:0] HIGH_ADDR = `CCSR_ADDR_P0_HIGH
) (
  // Clock and reset.
  input  wire logic  clk,
  input  wire logic  rst,
  // Register access.
  input  ccsr_sfr_s  special_register_space,
  // Pointer value.
  output logic [15:0] ptr_q
);

  // =====================================================================
  // Each byte takes its own address; page selection plays no part.
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= {`CCSR_RESET_BYTE, `CCSR_RESET_BYTE};
    end else if (special_register_space.wr && special_register_space.addr == LOW_ADDR) begin
      ptr_q[7:0] <= special_register_space.wdata;
    end else if (special_register_space.wr && special_register_space.addr == HIGH_ADDR) begin
      ptr_q[15:8] <= special_register_space.wdata;
    end
  end

endmodule : ccsr_ptr

/* hw/ccsr_top.sv */
`timescale 1ns/10ps
`include "ccsr_regs.svh"

// Core register set: accumulator, operand register, pointers and status.
module ccsr_top
  import ccsr_pkg::*;
(
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  // Special-register access from the execution unit.
  input  wire logic        SFR_WR,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic [7:0]  SFR_WDATA,
  output logic      [7:0]  SFR_RDATA,
  output logic             SFR_HIT,
  // Arithmetic execution.
  input  wire logic [2:0]  ALU_OP,
  input  wire logic [7:0]  ALU_OPERAND,
  // Pointer increment and system events.
  input  wire logic        PTR_INC,
  input  wire logic        WAKE_EVENT,
  input  wire logic        HOLD_EVENT,
  // Outputs towards the core.
  output logic      [15:0] EXT_ADDR,
  output logic      [4:0]  BANK_BASE,
  output logic             IDLE_MODE,
  output logic             POWER_DOWN_MODE,
  output logic             UART_DOUBLE_RATE,
  output logic             UART_ENABLE_OUT,
  output logic      [7:0]  ACC_OUT,
  output logic      [7:0]  PSW_OUT
);

  ccsr_sfr_s   special_register_space;
  ccsr_alu_s   alu_req;
  ccsr_flags_s alu_rsp;
  ccsr_op_e    op;
  logic [7:0]  acc_q;
  logic [7:0]  muldiv_q;
  logic [7:0]  pwr_q;
  logic [7:0]  psw_q;
  logic        hold_q;
  logic        parity;
  logic        arith;
  logic        muldiv_op;
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic        ptr_sel;

  // =====================================================================
  // Bundling of inputs into the package carriers.
  assign special_register_space     = '{wr: SFR_WR, addr: SFR_ADDR, wdata: SFR_WDATA};
  assign op      = ccsr_op_e'(ALU_OP);
  assign arith   = op != CCSR_OP_NONE;
  assign muldiv_op = (op == CCSR_OP_MUL) || (op == CCSR_OP_DIV);
  // Multiply and divide take their second operand from the operand register.
  assign alu_req = '{op: op, a: acc_q, b: muldiv_op ? muldiv_q : ALU_OPERAND,
                     cin: psw_q[`CCSR_PSW_CARRY]};

  ccsr_arith u_arith (
    .req (alu_req),
    .rsp (alu_rsp)
  );

  // Pointer increment is held in a shadow register; the byte-wise modules see only register writes.
  logic [15:0] ptr_next;
  ccsr_sfr_s   sfr0;
  ccsr_sfr_s   sfr1;
  // The live selected value is used, not the registered address, so that
  // two increments in a row do not reuse a stale pointer.
  assign ptr_next = (ptr_sel ? ptr1_eff : ptr0_eff) + 16'h0001;

  ccsr_ptr #(.LOW_ADDR(`CCSR_ADDR_P0_LOW), .HIGH_ADDR(`CCSR_ADDR_P0_HIGH)) u_ptr0 (
    .clk   (REF_CLK),
    .rst   (SRST),
    .special_register_space   (sfr0),
    .ptr_q (ptr0_q)
  );

  ccsr_ptr #(.LOW_ADDR(`CCSR_ADDR_P1_LOW), .HIGH_ADDR(`CCSR_ADDR_P1_HIGH)) u_ptr1 (
    .clk   (REF_CLK),
    .rst   (SRST),
    .special_register_space   (sfr1),
    .ptr_q (ptr1_q)
  );

  // =====================================================================
  // Pointer increment needs both bytes at once, so it is kept outside
  // the byte-wise pointer module through a shadow register.
  logic [15:0] inc0_q;
  logic [15:0] inc1_q;
  logic        inc0_v_q;
  logic        inc1_v_q;
  assign sfr0 = special_register_space;
  assign sfr1 = special_register_space;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      inc0_v_q <= 1'b0;
      inc1_v_q <= 1'b0;
      inc0_q   <= 16'h0000;
      inc1_q   <= 16'h0000;
    end else begin
      if (special_register_space.wr && (special_register_space.addr == `CCSR_ADDR_P0_LOW || special_register_space.addr == `CCSR_ADDR_P0_HIGH)) begin
        inc0_v_q <= 1'b0;
      end else if (PTR_INC && !ptr_sel) begin
        inc0_v_q <= 1'b1;
        inc0_q   <= ptr_next;
      end
      if (special_register_space.wr && (special_register_space.addr == `CCSR_ADDR_P1_LOW || special_register_space.addr == `CCSR_ADDR_P1_HIGH)) begin
        inc1_v_q <= 1'b0;
      end else if (PTR_INC && ptr_sel) begin
        inc1_v_q <= 1'b1;
        inc1_q   <= ptr_next;
      end
    end
  end

  // Effective pointer values; a byte write after an increment keeps the
  // other byte from the incremented value.
  logic [15:0] ptr0_eff;
  logic [15:0] ptr1_eff;
  logic [15:0] base0_q;
  logic [15:0] base1_q;
  assign ptr0_eff = inc0_v_q ? inc0_q : base0_q;
  assign ptr1_eff = inc1_v_q ? inc1_q : base1_q;

  // Byte writes merge into the effective value so an earlier increment is not lost; an increment in the write's own cycle is dropped.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      base0_q <= 16'h0000;
      base1_q <= 16'h0000;
    end else begin
      if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_P0_LOW) begin
        base0_q <= {ptr0_eff[15:8], special_register_space.wdata};
      end else if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_P0_HIGH) begin
        base0_q <= {special_register_space.wdata, ptr0_eff[7:0]};
      end
      if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_P1_LOW) begin
        base1_q <= {ptr1_eff[15:8], special_register_space.wdata};
      end else if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_P1_HIGH) begin
        base1_q <= {special_register_space.wdata, ptr1_eff[7:0]};
      end
    end
  end

  // =====================================================================
  // Pointer selection drives the external data address.
  assign ptr_sel = pwr_q[`CCSR_PWR_SEL];
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      EXT_ADDR <= 16'h0000;
    end else begin
      EXT_ADDR <= ptr_sel ? ptr1_eff : ptr0_eff;
    end
  end

  // =====================================================================
  // Accumulator: arithmetic results take priority over register writes.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      acc_q <= `CCSR_RESET_BYTE;
    end else if (arith && !(op == CCSR_OP_DIV && alu_rsp.range)) begin
      acc_q <= alu_rsp.res;
    end else if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_ACC) begin
      acc_q <= special_register_space.wdata;
    end
  end

  // Operand register receives the high product or remainder.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      muldiv_q <= `CCSR_RESET_BYTE;
    end else if (muldiv_op && !alu_rsp.range) begin
      muldiv_q <= alu_rsp.res_b;
    end else if (op == CCSR_OP_MUL) begin
      muldiv_q <= alu_rsp.res_b;
    end else if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_MULDIV) begin
      muldiv_q <= special_register_space.wdata;
    end
  end

  // =====================================================================
  // Power control; the sleep bit clears itself on wake.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pwr_q <= `CCSR_RESET_BYTE;
    end else begin
      if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_PWR) begin
        pwr_q <= special_register_space.wdata;
      end
      if (WAKE_EVENT && pwr_q[`CCSR_PWR_SLEEP]) begin
        pwr_q[`CCSR_PWR_SLEEP] <= 1'b0;
      end
    end
  end

  assign IDLE_MODE        = pwr_q[`CCSR_PWR_SLEEP] && !pwr_q[`CCSR_PWR_DOWN];
  assign POWER_DOWN_MODE  = pwr_q[`CCSR_PWR_SLEEP] && pwr_q[`CCSR_PWR_DOWN];
  assign UART_DOUBLE_RATE = pwr_q[`CCSR_PWR_DOUBLE];
  assign UART_ENABLE_OUT  = pwr_q[`CCSR_PWR_UART_EN];

  // =====================================================================
  // Status word: write first, then arithmetic flags override it.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      psw_q <= `CCSR_RESET_BYTE;
    end else begin
      if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_PSW_MAIN) begin
        psw_q <= special_register_space.wdata;
      end
      if (op == CCSR_OP_ADD || op == CCSR_OP_ADDC || op == CCSR_OP_SUBB) begin
        psw_q[`CCSR_PSW_CARRY] <= alu_rsp.carry;
        psw_q[`CCSR_PSW_AUX]   <= alu_rsp.aux;
      end
      if (op == CCSR_OP_MUL || op == CCSR_OP_DIV) begin
        psw_q[`CCSR_PSW_CARRY] <= 1'b0;
      end
      if (arith) begin
        psw_q[`CCSR_PSW_RANGE] <= alu_rsp.range;
      end
    end
  end

  // Parity follows the accumulator continuously and is never stored.
  assign parity  = ^acc_q;
  assign PSW_OUT = {psw_q[7:1], parity};
  assign ACC_OUT = acc_q;
  assign BANK_BASE = {psw_q[`CCSR_PSW_BANK_HI], psw_q[`CCSR_PSW_BANK_LO], 3'b000};

  // =====================================================================
  // Hold flag: a hardware set wins over a software clear.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      hold_q <= 1'b0;
    end else if (HOLD_EVENT) begin
      hold_q <= 1'b1;
    end else if (special_register_space.wr && special_register_space.addr == `CCSR_ADDR_PSW_HOLD) begin
      hold_q <= special_register_space.wdata[`CCSR_HOLD_FLAG];
    end
  end

  // =====================================================================
  // Read decode ignores any page selection.
  always_comb begin
    SFR_HIT   = 1'b1;
    unique case (SFR_ADDR)
      `CCSR_ADDR_P0_LOW:   SFR_RDATA = ptr0_eff[7:0];
      `CCSR_ADDR_P0_HIGH:  SFR_RDATA = ptr0_eff[15:8];
      `CCSR_ADDR_P1_LOW:   SFR_RDATA = ptr1_eff[7:0];
      `CCSR_ADDR_P1_HIGH:  SFR_RDATA = ptr1_eff[15:8];
      `CCSR_ADDR_PWR:      SFR_RDATA = pwr_q;
      `CCSR_ADDR_PSW_MAIN: SFR_RDATA = PSW_OUT;
      `CCSR_ADDR_PSW_HOLD: SFR_RDATA = {7'h00, hold_q};
      `CCSR_ADDR_ACC:      SFR_RDATA = acc_q;
      `CCSR_ADDR_MULDIV:   SFR_RDATA = muldiv_q;
      default: begin
        SFR_RDATA = 8'h00;
        SFR_HIT   = 1'b0;
      end
    endcase
  end

  // =====================================================================
  // Checks.
  a_parity_tracks: assert property (@(posedge REF_CLK) disable iff (SRST)
    PSW_OUT[0] == ^ACC_OUT) else $error("parity mismatch");
  a_range_divzero: assert property (@(posedge REF_CLK) disable iff (SRST)
    (op == CCSR_OP_DIV && muldiv_q == 8'h00) |=> psw_q[`CCSR_PSW_RANGE]) else $error("div zero not flagged");
  a_range_mul: assert property (@(posedge REF_CLK) disable iff (SRST)
    (op == CCSR_OP_MUL) |=> psw_q[`CCSR_PSW_RANGE] == ($past(acc_q) * $past(muldiv_q) > `CCSR_BYTE_MAX))
    else $error("mul range");
  a_user_flags: assert property (@(posedge REF_CLK) disable iff (SRST)
    !(special_register_space.wr && special_register_space.addr == `CCSR_ADDR_PSW_MAIN) |=> $stable({psw_q[5], psw_q[1]})) else $error("user flag moved");
  a_hold_sticky: assert property (@(posedge REF_CLK) disable iff (SRST)
    HOLD_EVENT |=> hold_q) else $error("hold lost");
  a_sleep_wake: assert property (@(posedge REF_CLK) disable iff (SRST)
    (WAKE_EVENT && pwr_q[`CCSR_PWR_SLEEP] && !special_register_space.wr) |=> !pwr_q[`CCSR_PWR_SLEEP]) else $error("sleep not cleared");
  a_ptr_select: assert property (@(posedge REF_CLK) disable iff (SRST)
    EXT_ADDR == ($past(ptr_sel) ? $past(ptr1_eff) : $past(ptr0_eff))) else $error("pointer select");
  a_flag_priority: assert property (@(posedge REF_CLK) disable iff (SRST)
    (op == CCSR_OP_ADD && special_register_space.wr && special_register_space.addr == `CCSR_ADDR_PSW_MAIN) |=> psw_q[7] == $past(alu_rsp.carry))
    else $error("flag priority");

endmodule : ccsr_top

/* verification/ccsr_exec_model.sv */
`timescale 1ns/10ps

// =====================================================================
// Execution-unit stand-in: issues register accesses and arithmetic steps.
module ccsr_exec_model
  import ccsr_pkg::*;
(
  // Clock.
  input  wire logic       clk,
  // Requests towards the register set.
  output logic            wr,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic      [2:0] op,
  output logic      [7:0] operand,
  // Event pulses: increment, wake, hold.
  output logic            inc,
  output logic            wake,
  output logic            hold
);
  // Quiet bus at time zero, so the register set never sees an unknown request.
  initial begin
    {wr, addr, wdata, op, operand, inc, wake, hold} = '0;
  end

  // One-cycle request; a write may share its cycle with an arithmetic step.
  task automatic step(input logic w, input logic [7:0] a, d, input logic [2:0] o,
                      input logic [7:0] x, input logic [2:0] ev);
    @(posedge clk);
    {wr, addr, wdata, op, operand, inc, wake, hold} <= {w, a, d, o, x, ev};
    @(posedge clk);
    {wr, op, inc, wake, hold} <= '0;
  endtask : step

  // Address only; the read data is combinational, so no strobe is needed.
  task automatic look(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    wr   <= 1'b0;
  endtask : look
endmodule : ccsr_exec_model

/* verification/test_cpu_core_status_registers.sv */
`timescale 1ns/10ps
`include "ccsr_regs.svh"

// Compares a design value with the expected one and counts both outcomes.
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

// =====================================================================
// Self-checking bench for the core register set.
module test_cpu_core_status_registers
  import ccsr_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        sfr_wr, sfr_hit, ptr_inc, wake_event, hold_event;
  logic        idle_mode, power_down_mode, uart_double_rate, uart_enable_out;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, alu_operand, acc_out, psw_out;
  logic [2:0]  alu_op;
  logic [4:0]  bank_base;
  logic [15:0] ext_addr;
  int          error_cnt = 0;
  int          checks = 0;
  logic [7:0]  acc_m = 8'h00;
  logic [7:0]  b_m = 8'h00;
  logic [7:0]  psw_m = 8'h00;
  logic [7:0]  addr_t [6] = '{`CCSR_ADDR_P0_LOW, `CCSR_ADDR_P0_HIGH, `CCSR_ADDR_P1_LOW,
                              `CCSR_ADDR_P1_HIGH, `CCSR_ADDR_ACC, `CCSR_ADDR_MULDIV};
  logic [7:0]  val_t [6];
  logic [7:0]  pwr_t [4] = '{8'h36, 8'hC0, 8'h01, 8'h03};
  logic [3:0]  mode_t [4] = '{4'b0000, 4'b0011, 4'b1000, 4'b0100};

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  ccsr_exec_model i_exec (.clk(clk), .wr(sfr_wr), .addr(sfr_addr), .wdata(sfr_wdata), .op(alu_op),
                          .operand(alu_operand), .inc(ptr_inc), .wake(wake_event), .hold(hold_event));

  ccsr_top i_dut (.REF_CLK(clk), .SRST(srst), .SFR_WR(sfr_wr), .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata),
                  .SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit), .ALU_OP(alu_op), .ALU_OPERAND(alu_operand),
                  .PTR_INC(ptr_inc), .WAKE_EVENT(wake_event), .HOLD_EVENT(hold_event), .EXT_ADDR(ext_addr),
                  .BANK_BASE(bank_base), .IDLE_MODE(idle_mode), .POWER_DOWN_MODE(power_down_mode),
                  .UART_DOUBLE_RATE(uart_double_rate), .UART_ENABLE_OUT(uart_enable_out),
                  .ACC_OUT(acc_out), .PSW_OUT(psw_out));

  // Reference arithmetic: {acc, operand reg, carry, aux, range}; plain add ignores carry in.
  function automatic logic [18:0] alu_ref(input logic [2:0] o, input logic [7:0] a, bb, x,
                                          input logic cy, ac);
    logic [8:0]  s;
    logic [4:0]  n;
    logic [15:0] p;
    logic        c;
    c = (o == CCSR_OP_ADD) ? 1'b0 : cy;
    case (o)
      CCSR_OP_ADD, CCSR_OP_ADDC: begin
        s = a + x + c;
        n = a[3:0] + x[3:0] + c;
        return {s[7:0], bb, s[8], n[4], (a[7] == x[7]) && (s[7] != a[7])};
      end
      CCSR_OP_SUBB: begin
        s = {1'b0, a} - x - c;
        n = {1'b0, a[3:0]} - x[3:0] - c;
        return {s[7:0], bb, s[8], n[4], (a[7] != x[7]) && (s[7] != a[7])};
      end
      CCSR_OP_MUL: begin
        p = a * bb;
        return {p[7:0], p[15:8], 1'b0, ac, p > 16'h00FF};
      end
      default: return (bb == 8'h00) ? {a, bb, 1'b0, ac, 1'b1} : {a / bb, a % bb, 1'b0, ac, 1'b0};
    endcase
  endfunction : alu_ref

  // Register write through the execution unit.
  task automatic wr(input logic [7:0] a, d);
    i_exec.step(1'b1, a, d, 3'b000, 8'h00, 3'b000);
  endtask : wr

  // Register read; data is sampled once the address has settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_exec.look(a);
    #1;
    d = sfr_rdata;
  endtask : rd

  // Read and compare data and address decode.
  task automatic rdchk(input logic [7:0] a, e, input logic h);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
    `CHK(sfr_hit, h)
  endtask : rdchk

  // Arithmetic step, optionally with a status write in the same cycle.
  task automatic alu_case(input logic [2:0] o, input logic [7:0] x, input logic wp, input logic [7:0] pv);
    logic [18:0] r;
    logic [7:0]  base;
    logic [7:0]  d;
    base = wp ? pv : psw_m;
    r = alu_ref(o, acc_m, b_m, x, psw_m[7], base[6]);
    i_exec.step(wp, `CCSR_ADDR_PSW_MAIN, pv, o, x, 3'b000);
    {acc_m, b_m, base[7], base[6], base[2]} = r;
    psw_m = base;
    #1;
    `CHK(acc_out, acc_m)
    `CHK(psw_out[7:1], psw_m[7:1])
    `CHK(psw_out[0], ^acc_m)
    `CHK(bank_base, {psw_m[4:3], 3'b000})
    rd(`CCSR_ADDR_MULDIV, d);
    `CHK(d, b_m)
  endtask : alu_case

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // Watchdog: the tests need a few hundred cycles, so this only trips on a hang.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h07B1));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // Every register but the main status word is checked for zero after reset; an unmapped place ignores writes.
    for (int i = 0; i < 6; i++) begin
      rdchk(addr_t[i], 8'h00, 1'b1);
    end
    rdchk(`CCSR_ADDR_PWR, 8'h00, 1'b1);
    rdchk(`CCSR_ADDR_PSW_HOLD, 8'h00, 1'b1);
    wr(8'h86, 8'hA5);
    rdchk(8'h86, 8'h00, 1'b0);
    $display("test reset done");
    // Random round trip through accumulator, operand register and pointer bytes.
    for (int i = 0; i < 6; i++) begin
      val_t[i] = 8'($urandom);
      wr(addr_t[i], val_t[i]);
      rdchk(addr_t[i], val_t[i], 1'b1);
    end
    acc_m = val_t[4];
    b_m = val_t[5];
    wr(`CCSR_ADDR_PWR, 8'h08);
    @(posedge clk);
    #1;
    `CHK(ext_addr, {val_t[3], val_t[2]})
    i_exec.step(1'b0, 8'h00, 8'h00, 3'b000, 8'h00, 3'b100);
    @(posedge clk);
    #1;
    `CHK(ext_addr, 16'({val_t[3], val_t[2]} + 16'h0001))
    wr(`CCSR_ADDR_PWR, 8'h00);
    @(posedge clk);
    #1;
    `CHK(ext_addr, {val_t[1], val_t[0]})
    $display("test pointers done");
    // Power control fields, reserved bits and wake-up.
    for (int i = 0; i < 4; i++) begin
      wr(`CCSR_ADDR_PWR, pwr_t[i]);
      #1;
      `CHK({idle_mode, power_down_mode, uart_double_rate, uart_enable_out}, mode_t[i])
      rdchk(`CCSR_ADDR_PWR, pwr_t[i], 1'b1);
    end
    wr(`CCSR_ADDR_PWR, 8'h41);
    i_exec.step(1'b0, `CCSR_ADDR_PWR, 8'h00, 3'b000, 8'h00, 3'b010);
    #1;
    `CHK(idle_mode, 1'b0)
    rdchk(`CCSR_ADDR_PWR, 8'h40, 1'b1);
    $display("test power done");
    // Hold flag is sticky until software clears it; upper bits read zero.
    i_exec.step(1'b0, 8'h00, 8'h00, 3'b000, 8'h00, 3'b001);
    repeat (5) @(posedge clk);
    rdchk(`CCSR_ADDR_PSW_HOLD, 8'h01, 1'b1);
    wr(`CCSR_ADDR_PSW_HOLD, 8'hFE);
    rdchk(`CCSR_ADDR_PSW_HOLD, 8'h00, 1'b1);
    $display("test hold done");
    // Random arithmetic with a zero divisor and status shuffles among it.
    for (int i = 0; i < 60; i++) begin
      if (i % 8 == 0) begin
        psw_m = 8'($urandom);
        wr(`CCSR_ADDR_PSW_MAIN, psw_m);
      end
      if (i % 4 == 0) begin
        acc_m = 8'($urandom);
        wr(`CCSR_ADDR_ACC, acc_m);
      end
      if (i % 7 == 0) begin
        b_m = (i % 14 == 0) ? 8'h00 : 8'($urandom);
        wr(`CCSR_ADDR_MULDIV, b_m);
      end
      alu_case(3'($urandom_range(5, 1)), 8'($urandom), 1'b0, 8'h00);
    end
    alu_case(CCSR_OP_DIV, 8'h00, 1'b0, 8'h00);
    $display("test arithmetic done");
    // Flag update wins over a status write in the same cycle.
    acc_m = 8'hFF;
    wr(`CCSR_ADDR_ACC, acc_m);
    alu_case(CCSR_OP_ADD, 8'h01, 1'b1, 8'h00);
    alu_case(CCSR_OP_ADD, 8'h7F, 1'b1, 8'hFE);
    $display("test priority done");
    complete_run();
  end
endmodule : test_cpu_core_status_registers
